// ==== rtl/uart_irq_pkg.sv ====
// shared constants and carriers for the channel interrupt logic
package uart_irq_pkg;
    // ------------------------------------------------------------
    // interrupt enable bit positions
    // ------------------------------------------------------------
    localparam int IE_RX_DATA   = 0;
    localparam int IE_TX_READY  = 1;
    localparam int IE_LINE      = 2;
    localparam int IE_MODEM     = 3;
    localparam int IE_XOFF      = 5;
    localparam int IE_OUT_PIN   = 6;
    localparam int IE_IN_PIN    = 7;
    localparam logic [7:0] IE_RESET     = 8'h00;
    localparam logic [7:0] IE_WRITE_MSK = 8'hef;

    // ------------------------------------------------------------
    // source codes, bits 5:0
    // ------------------------------------------------------------
    localparam logic [5:0] SRC_LINE    = 6'h06;
    localparam logic [5:0] SRC_RX_DATA = 6'h04;
    localparam logic [5:0] SRC_TIMEOUT = 6'h0c;
    localparam logic [5:0] SRC_TX      = 6'h02;
    localparam logic [5:0] SRC_MODEM   = 6'h00;
    localparam logic [5:0] SRC_FLOWCH  = 6'h10;
    localparam logic [5:0] SRC_PIN     = 6'h20;
    localparam logic [5:0] SRC_NONE    = 6'h01;
    localparam logic [7:0] SRC_RESET   = 8'h01;
    // both transmit empty flags up, nothing received
    localparam logic [7:0] LSR_RESET   = 8'h60;

    // ------------------------------------------------------------
    // timing: timeout = 4 chars + 12 bits, in bit times
    // ------------------------------------------------------------
    localparam int TO_CHARS    = 4;
    localparam int TO_BITS     = 12;
    localparam int CNT_W       = 16;

    // register access strobes from the host bus decoder
    typedef struct packed {
        logic       ie_wr;
        logic [7:0] ie_wdata;
        logic       src_rd;
        logic       line_rd;
        logic       modem_rd;
        logic       rx_rd;
        logic       tx_wr;
        logic       gsrc0_rd;
    } host_acc_t;

    // channel configuration held elsewhere
    typedef struct packed {
        logic fifo_en;
        logic ext_en;
        logic auto_in_flow;
        logic auto_out_flow;
        logic pin_sel;
        logic auto_hdx;
    } chan_cfg_t;
endpackage

// ==== rtl/sync_rise.sv ====
// two-stage synchroniser with rising edge pulse
module sync_rise
    import uart_irq_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic din,
    output logic      level,
    output logic      rise
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= din;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level = sync_q;
    assign rise  = sync_q & ~prev_q;
endmodule

// ==== rtl/rx_timeout.sv ====
// receive idle timer: four characters plus twelve bits of silence
module rx_timeout
    import uart_irq_pkg::*;
#(
    parameter int W = CNT_W
)(
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic         bit_tick,
    input  wire logic [3:0]   char_bits,
    input  wire logic         rx_empty,
    input  wire logic         activity,
    output logic              expired
);
    // the longest limit is 4 * 15 + 12 bit times, which needs seven bits
    if (W < 8) begin : g_width_check
        $error("rx_timeout: counter too narrow");
    end

    logic [W-1:0] cnt_q;
    logic [W-1:0] limit;

    // limit = 4 * char_bits + 12 bit times
    assign limit = W'(TO_CHARS) * W'(char_bits) + W'(TO_BITS);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (rx_empty || activity) begin
            cnt_q <= '0;
        end else if (bit_tick && cnt_q < limit) begin
            cnt_q <= cnt_q + W'(1);
        end
    end

    assign expired = !rx_empty && (cnt_q >= limit);
endmodule

// ==== rtl/uart_interrupt_logic.sv ====
// per-channel interrupt masking, priority, status and clearing
// Function
// - fifo mode: rx data interrupt follows trigger level, drops below it
// - data ready set on character arrival, cleared when fifo empties
// - line status bits 0,1,5,6 show data, overrun, tx empty, all empty
// - bits 2-4 describe head byte; bit 7 any error in fifo
// - enable bit 7 or 6 with extension: rising input flow pin interrupts
// - enable bit 6 or 7 with extension: rising output flow pin interrupts
// - enable bit 5 gates xoff interrupt; bit 4 reserved
// - enable bit 3: modem delta bits raise modem interrupt
// - enable bit 2: line error on arrival and again at fifo head
// - enable bit 1: tx ready when empty, or twice in fifo mode
// - half duplex: second tx interrupt waits for shifter empty too
// - enable bit 0: rx data on holding full or fifo trigger
// - source register shows highest pending; others wait
// - timeout after four characters plus twelve bit times
// - pin change only under auto flow, pin pair by modem control bit 2
// - wake-up posted on leaving sleep, cleared by global source read
// - line read clears line; modem read clears modem and pin change
// - holding read clears timeout; rx data clears under trigger
// - tx ready clears on source read or holding write
// - flow characters clear on source read; special also on next char
// - channel source mirrored to global source outputs
// - source codes encode priority levels
// - bit 0 low while pending, high when idle
// - bits 7:6 follow fifo enable
module uart_interrupt_logic
    import uart_irq_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  host_acc_t       acc,
    input  chan_cfg_t       cfg,
    input  wire logic [4:0] rx_level,
    input  wire logic [4:0] rx_trigger,
    input  wire logic       rx_push,
    input  wire logic       rx_push_err,
    input  wire logic       head_overrun,
    input  wire logic [2:0] head_err,
    input  wire logic       head_has_err,
    input  wire logic       fifo_err_any,
    input  wire logic [4:0] tx_level,
    input  wire logic [4:0] tx_trigger,
    input  wire logic       tsr_empty,
    input  wire logic [3:0] modem_delta,
    input  wire logic       xoff_seen,
    input  wire logic       special_seen,
    input  wire logic       cts_pin,
    input  wire logic       dsr_pin,
    input  wire logic       rts_out,
    input  wire logic       dtr_out,
    input  wire logic       sleep_exit,
    input  wire logic       bit_tick,
    input  wire logic [3:0] char_bits,
    output logic [7:0]      interrupt_enable_reg,
    output logic [7:0]      interrupt_source_reg,
    output logic [7:0]      line_status_reg,
    output logic [5:0]      global_source,
    output logic            irq
);
    // ------------------------------------------------------------
    // pins from outside are synchronised first
    // ------------------------------------------------------------
    logic in_rise_c, in_rise_d;
    logic out_rise_r, out_rise_d;

    // only the rising edges matter here, the pin levels are not needed
    sync_rise u_cts (.clk_sys(clk_sys), .rst(rst), .din(cts_pin), .level(),
                     .rise(in_rise_c));
    sync_rise u_dsr (.clk_sys(clk_sys), .rst(rst), .din(dsr_pin), .level(),
                     .rise(in_rise_d));

    // output pins are our own logic, so only an edge detector is needed
    logic rts_prev_q, dtr_prev_q;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rts_prev_q <= 1'b0;
            dtr_prev_q <= 1'b0;
        end else begin
            rts_prev_q <= rts_out;
            dtr_prev_q <= dtr_out;
        end
    end
    assign out_rise_r = rts_out & ~rts_prev_q;
    assign out_rise_d = dtr_out & ~dtr_prev_q;

    // ------------------------------------------------------------
    // enable register
    // ------------------------------------------------------------
    logic [7:0] ie_q;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ie_q <= IE_RESET;
        end else if (acc.ie_wr) begin
            // bits 7:5 only writable with the extension enabled, bit 4 reserved
            ie_q <= acc.ie_wdata & IE_WRITE_MSK
                    & (cfg.ext_en ? 8'hff : 8'h1f);
        end
    end

    // ------------------------------------------------------------
    // level-type sources
    // ------------------------------------------------------------
    logic rx_empty, rx_data_lvl, tx_empty, tx_below;
    assign rx_empty    = (rx_level == 5'h00);
    // non-fifo mode: holding register full counts as trigger
    assign rx_data_lvl = cfg.fifo_en ? (rx_level >= rx_trigger) : !rx_empty;
    assign tx_empty    = (tx_level == 5'h00);
    assign tx_below    = tx_level < tx_trigger;

    logic to_exp;
    rx_timeout u_to (.clk_sys(clk_sys), .rst(rst), .bit_tick(bit_tick),
                     .char_bits(char_bits), .rx_empty(rx_empty),
                     .activity(rx_push | acc.rx_rd), .expired(to_exp));

    // ------------------------------------------------------------
    // sticky sources: set wins over clear, except timeout, where a holding read wins
    // ------------------------------------------------------------
    logic line_q, tmo_q, tx_q, flow_q, spec_q, pin_q, wake_q;
    logic head_err_prev_q, tx_below_prev_q, tx_done_prev_q;
    logic tx_done;
    // half-duplex holds the second event until the shifter has drained
    assign tx_done = cfg.auto_hdx ? (tx_empty & tsr_empty) : tx_empty;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            head_err_prev_q <= 1'b0;
            tx_below_prev_q <= 1'b1;
            tx_done_prev_q  <= 1'b1;
        end else begin
            head_err_prev_q <= head_has_err;
            tx_below_prev_q <= tx_below;
            tx_done_prev_q  <= tx_done;
        end
    end

    logic line_set, tx_set, pin_set;
    // error on arrival, and again when the bad byte reaches the head
    assign line_set = rx_push_err | (head_has_err & ~head_err_prev_q);
    assign tx_set   = cfg.fifo_en ? ((tx_below & ~tx_below_prev_q)
                                     | (tx_done & ~tx_done_prev_q))
                                  : (tx_empty & ~tx_done_prev_q);
    assign pin_set  = cfg.ext_en & ((cfg.auto_in_flow
                          & (cfg.pin_sel ? in_rise_d : in_rise_c))
                        | (cfg.auto_out_flow
                          & (cfg.pin_sel ? out_rise_d : out_rise_r)));

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            line_q <= 1'b0;
        end else if (line_set) begin
            line_q <= 1'b1;
        end else if (acc.line_rd) begin
            line_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tmo_q <= 1'b0;
        end else if (acc.rx_rd) begin
            tmo_q <= 1'b0;
        end else if (to_exp) begin
            tmo_q <= 1'b1;
        end
    end

    logic src_rd_tx, src_rd_flow;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tx_q <= 1'b0;
        end else if (tx_set) begin
            tx_q <= 1'b1;
        end else if (acc.tx_wr || src_rd_tx) begin
            tx_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            flow_q <= 1'b0;
            spec_q <= 1'b0;
        end else begin
            if (xoff_seen) begin
                flow_q <= 1'b1;
            end else if (src_rd_flow) begin
                flow_q <= 1'b0;
            end
            if (special_seen) begin
                spec_q <= 1'b1;
            end else if (src_rd_flow || rx_push) begin
                spec_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pin_q  <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            if (pin_set) begin
                pin_q <= 1'b1;
            end else if (acc.modem_rd) begin
                pin_q <= 1'b0;
            end
            if (sleep_exit) begin
                wake_q <= 1'b1;
            end else if (acc.gsrc0_rd) begin
                wake_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // priority encode
    // ------------------------------------------------------------
    logic       e_line, e_rx, e_tmo, e_tx, e_mdm, e_flow, e_pin, any_en;
    logic [5:0] code;
    assign e_line = ie_q[IE_LINE] & line_q;
    assign e_rx   = ie_q[IE_RX_DATA] & rx_data_lvl;
    assign e_tmo  = ie_q[IE_RX_DATA] & tmo_q;
    assign e_tx   = ie_q[IE_TX_READY] & tx_q;
    assign e_mdm  = ie_q[IE_MODEM] & (|modem_delta);
    assign e_flow = cfg.ext_en & ((ie_q[IE_XOFF] & flow_q) | spec_q);
    assign e_pin  = cfg.ext_en & pin_q
                    & (ie_q[IE_IN_PIN] | ie_q[IE_OUT_PIN]);
    assign any_en = e_line | e_rx | e_tmo | e_tx | e_mdm | e_flow | e_pin;

    always_comb begin
        if      (e_line) code = SRC_LINE;
        else if (e_rx)   code = SRC_RX_DATA;
        else if (e_tmo)  code = SRC_TIMEOUT;
        else if (e_tx)   code = SRC_TX;
        else if (e_mdm)  code = SRC_MODEM;
        else if (e_flow) code = SRC_FLOWCH;
        else if (e_pin)  code = SRC_PIN;
        else             code = SRC_NONE;
    end

    // a source read only acknowledges what it presented
    assign src_rd_tx   = acc.src_rd && interrupt_source_reg[5:0] == SRC_TX;
    assign src_rd_flow = acc.src_rd && interrupt_source_reg[5:0] == SRC_FLOWCH;

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            interrupt_source_reg <= SRC_RESET;
            global_source        <= SRC_NONE;
            irq                  <= 1'b0;
            interrupt_enable_reg <= IE_RESET;
        end else begin
            interrupt_source_reg <= {{2{cfg.fifo_en}}, code};
            // wake-up shares the idle code but still flags the device level
            global_source        <= code;
            irq                  <= any_en | wake_q;
            interrupt_enable_reg <= ie_q;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            line_status_reg <= LSR_RESET;
        end else begin
            line_status_reg <= {fifo_err_any,
                                tx_empty & tsr_empty,
                                tx_empty,
                                head_err,
                                head_overrun,
                                !rx_empty};
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_idle_code: assert property (@(posedge clk_sys) disable iff (rst)
        !any_en |=> interrupt_source_reg[0] == 1'b1)
        else $error("idle source code wrong");
    a_irq_follow: assert property (@(posedge clk_sys) disable iff (rst)
        any_en |=> irq)
        else $error("irq not raised");
    a_line_first: assert property (@(posedge clk_sys) disable iff (rst)
        e_line |=> interrupt_source_reg[5:0] == SRC_LINE)
        else $error("line source not top");
    a_fifo_bits: assert property (@(posedge clk_sys) disable iff (rst)
        1'b1 |=> interrupt_source_reg[7:6] == {2{$past(cfg.fifo_en)}})
        else $error("fifo bits wrong");
    a_line_clear: assert property (@(posedge clk_sys) disable iff (rst)
        acc.line_rd && !line_set |=> !line_q)
        else $error("line not cleared");
    a_tmo_clear: assert property (@(posedge clk_sys) disable iff (rst)
        acc.rx_rd |=> !tmo_q)
        else $error("timeout not cleared");
    a_tx_write: assert property (@(posedge clk_sys) disable iff (rst)
        acc.tx_wr && !tx_set |=> !tx_q)
        else $error("tx ready not cleared");
    sequence s_wake_then_irq;
        wake_q ##1 irq;
    endsequence
    a_wake_set: assert property (@(posedge clk_sys) disable iff (rst)
        sleep_exit |=> s_wake_then_irq)
        else $error("wake-up lost");
    a_tmo_set: assert property (@(posedge clk_sys) disable iff (rst)
        to_exp && !acc.rx_rd |=> tmo_q)
        else $error("timeout not posted");
    a_data_ready: assert property (@(posedge clk_sys) disable iff (rst)
        rx_empty |=> !line_status_reg[0])
        else $error("data ready stuck");
endmodule

// ==== testbench/host_model.sv ====
// host side model driving register access strobes
module host_model
    import uart_irq_pkg::*;
(
    input  wire logic clk_sys,
    output host_acc_t acc
);
    timeunit 1ns;
    timeprecision 1ps;

    initial acc = '0;

    // ------------------------------------------------------------
    // one-cycle strobes, raised and dropped just after an edge
    // ------------------------------------------------------------
    task automatic ie_write(input logic [7:0] d);
        @(posedge clk_sys);
        #1 acc.ie_wr = 1'b1;
        acc.ie_wdata = d;
        @(posedge clk_sys);
        #1 acc = '0;
    endtask

    // 0 source read, 1 line read, 2 modem read, 3 rx read, 4 tx write, 5 global read
    task automatic touch(input int k);
        @(posedge clk_sys);
        #1 acc.src_rd = (k == 0);
        acc.line_rd = (k == 1);
        acc.modem_rd = (k == 2);
        acc.rx_rd = (k == 3);
        acc.tx_wr = (k == 4);
        acc.gsrc0_rd = (k == 5);
        @(posedge clk_sys);
        #1 acc = '0;
    endtask
endmodule

// ==== testbench/uart_interrupt_logic_tb.sv ====
// self-checking bench for the channel interrupt logic
module uart_interrupt_logic_tb
    import uart_irq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_sys, rst;
    host_acc_t acc;
    chan_cfg_t cfg;
    logic [4:0] rx_level, rx_trigger, tx_level, tx_trigger;
    logic rx_push, rx_push_err, head_overrun, head_has_err, fifo_err_any, tsr_empty;
    logic xoff_seen, special_seen, cts_pin, dsr_pin, rts_out, dtr_out, sleep_exit, bit_tick;
    logic [2:0] head_err;
    logic [3:0] modem_delta, char_bits;
    logic [7:0] ie_q, src_q, lsr_q;
    logic [5:0] gsrc;
    logic irq;
    int n_mismatch, n_checks;

    host_model host_model_inst (.clk_sys(clk_sys), .acc(acc));

    uart_interrupt_logic uart_interrupt_logic_inst (
        .clk_sys(clk_sys), .rst(rst), .acc(acc), .cfg(cfg), .rx_level(rx_level),
        .rx_trigger(rx_trigger), .rx_push(rx_push), .rx_push_err(rx_push_err),
        .head_overrun(head_overrun), .head_err(head_err), .head_has_err(head_has_err),
        .fifo_err_any(fifo_err_any), .tx_level(tx_level), .tx_trigger(tx_trigger),
        .tsr_empty(tsr_empty), .modem_delta(modem_delta), .xoff_seen(xoff_seen),
        .special_seen(special_seen), .cts_pin(cts_pin), .dsr_pin(dsr_pin),
        .rts_out(rts_out), .dtr_out(dtr_out), .sleep_exit(sleep_exit),
        .bit_tick(bit_tick), .char_bits(char_bits), .interrupt_enable_reg(ie_q),
        .interrupt_source_reg(src_q), .line_status_reg(lsr_q), .global_source(gsrc),
        .irq(irq));

    // ------------------------------------------------------------
    // clock, checks, waits
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // bit times at half the clock, so the timer sees gaps between ticks
    initial begin
        bit_tick = 1'b1;
        forever begin
            @(posedge clk_sys);
            #1 bit_tick = ~bit_tick;
        end
    end

    task automatic results();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // poll the source register, then let irq and the global copy settle
    task automatic wait_src(input logic [7:0] exp, input logic exp_irq);
        int i;
        i = 0;
        while (src_q !== exp && i < 200) begin
            @(posedge clk_sys);
            #1 i++;
        end
        if (i == 200) begin
            n_mismatch++;
            $display("[FAIL] %0t source never reached %h", $time, exp);
            results();
        end
        repeat (2) @(posedge clk_sys);
        #1 chk(src_q, exp);
        chk({2'b00, gsrc}, {2'b00, exp[5:0]});
        chk({7'd0, irq}, {7'd0, exp_irq});
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        @(posedge clk_sys);
        #1 s = 1'b0;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset_and_enable();
        wait_src(8'h01, 1'b0);
        chk(lsr_q, 8'h60);
        host_model_inst.ie_write(8'hff);
        idle(2);
        chk(ie_q, 8'h0f);
        cfg.ext_en = 1'b1;
        host_model_inst.ie_write(8'hff);
        idle(2);
        chk(ie_q, 8'hef);
        cfg.fifo_en = 1'b1;
        host_model_inst.ie_write(8'h00);
    endtask

    task automatic t_line_bits();
        rx_level = 5'd1;
        head_overrun = 1'b1;
        head_err = 3'b101;
        head_has_err = 1'b1;
        fifo_err_any = 1'b1;
        tx_level = 5'd2;
        tsr_empty = 1'b0;
        idle(4);
        chk(lsr_q, 8'h97);
        chk(src_q, 8'hc1);
        {rx_level, head_overrun, head_err, head_has_err, fifo_err_any} = '0;
        tx_level = 5'd0;
        tsr_empty = 1'b1;
        host_model_inst.touch(1);
        idle(4);
        chk(lsr_q, 8'h60);
    endtask

    task automatic t_rx_and_timeout();
        cfg.fifo_en = 1'b1;
        rx_trigger = 5'd8;
        host_model_inst.ie_write(8'h01);
        rx_level = 5'd8;
        wait_src(8'hc4, 1'b1);
        rx_level = 5'd7;
        wait_src(8'hc1, 1'b0);
        rx_level = 5'd1;
        char_bits = 4'd7;
        pulse(rx_push);
        idle(70);
        chk(src_q, 8'hc1);
        wait_src(8'hcc, 1'b1);
        host_model_inst.touch(3);
        wait_src(8'hc1, 1'b0);
        rx_level = 5'd0;
    endtask

    task automatic t_priority();
        host_model_inst.ie_write(8'h0c);
        modem_delta = 4'h1;
        rx_push = 1'b1;
        pulse(rx_push_err);
        rx_push = 1'b0;
        wait_src(8'hc6, 1'b1);
        host_model_inst.touch(1);
        wait_src(8'hc0, 1'b1);
        head_has_err = 1'b1;
        wait_src(8'hc6, 1'b1);
        host_model_inst.touch(1);
        head_has_err = 1'b0;
        wait_src(8'hc0, 1'b1);
        modem_delta = 4'h0;
        host_model_inst.touch(2);
        wait_src(8'hc1, 1'b0);
    endtask

    task automatic t_tx();
        tx_trigger = 5'd4;
        tx_level = 5'd5;
        host_model_inst.ie_write(8'h02);
        host_model_inst.touch(0);
        wait_src(8'hc1, 1'b0);
        tx_level = 5'd3;
        wait_src(8'hc2, 1'b1);
        host_model_inst.touch(0);
        wait_src(8'hc1, 1'b0);
        tx_level = 5'd0;
        wait_src(8'hc2, 1'b1);
        host_model_inst.touch(4);
        wait_src(8'hc1, 1'b0);
        cfg.auto_hdx = 1'b1;
        tsr_empty = 1'b0;
        tx_level = 5'd5;
        idle(4);
        tx_level = 5'd3;
        wait_src(8'hc2, 1'b1);
        host_model_inst.touch(0);
        tx_level = 5'd0;
        idle(10);
        chk(src_q, 8'hc1);
        tsr_empty = 1'b1;
        wait_src(8'hc2, 1'b1);
        host_model_inst.touch(4);
        wait_src(8'hc1, 1'b0);
    endtask

    task automatic t_pins_and_flow();
        host_model_inst.ie_write(8'h80);
        cts_pin = 1'b1;
        idle(10);
        chk(src_q, 8'hc1);
        cts_pin = 1'b0;
        cfg.auto_in_flow = 1'b1;
        idle(6);
        cts_pin = 1'b1;
        wait_src(8'he0, 1'b1);
        host_model_inst.touch(2);
        wait_src(8'hc1, 1'b0);
        cfg.auto_in_flow = 1'b0;
        cfg.auto_out_flow = 1'b1;
        host_model_inst.ie_write(8'h40);
        rts_out = 1'b1;
        wait_src(8'he0, 1'b1);
        host_model_inst.touch(2);
        wait_src(8'hc1, 1'b0);
        cfg.pin_sel = 1'b1;
        cfg.auto_in_flow = 1'b1;
        dsr_pin = 1'b1;
        wait_src(8'he0, 1'b1);
        host_model_inst.touch(2);
        wait_src(8'hc1, 1'b0);
        dtr_out = 1'b1;
        wait_src(8'he0, 1'b1);
        host_model_inst.touch(2);
        wait_src(8'hc1, 1'b0);
        host_model_inst.ie_write(8'h20);
        pulse(xoff_seen);
        wait_src(8'hd0, 1'b1);
        host_model_inst.touch(0);
        wait_src(8'hc1, 1'b0);
        pulse(special_seen);
        wait_src(8'hd0, 1'b1);
        pulse(rx_push);
        wait_src(8'hc1, 1'b0);
    endtask

    task automatic t_wake();
        host_model_inst.ie_write(8'h00);
        pulse(sleep_exit);
        idle(3);
        wait_src(8'hc1, 1'b1);
        host_model_inst.touch(5);
        idle(3);
        wait_src(8'hc1, 1'b0);
        cfg.fifo_en = 1'b0;
        wait_src(8'h01, 1'b0);
        host_model_inst.ie_write(8'h03);
        rx_level = 5'd1;
        wait_src(8'h04, 1'b1);
        rx_level = 5'd0;
        wait_src(8'h01, 1'b0);
        tx_level = 5'd1;
        idle(2);
        tx_level = 5'd0;
        wait_src(8'h02, 1'b1);
        host_model_inst.touch(4);
        wait_src(8'h01, 1'b0);
    endtask

    // ------------------------------------------------------------
    // main sequence; both pin pairs are exercised in the flow scenario
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        cfg = '0;
        {rx_level, rx_trigger, tx_level, tx_trigger} = '0;
        {rx_push, rx_push_err, head_overrun, head_has_err, fifo_err_any} = '0;
        {xoff_seen, special_seen, cts_pin, dsr_pin, rts_out, dtr_out, sleep_exit} = '0;
        {head_err, modem_delta} = '0;
        tsr_empty = 1'b1;
        char_bits = 4'd8;
        rx_trigger = 5'd4;
        n_mismatch = 0;
        n_checks = 0;
        repeat (4) @(posedge clk_sys);
        #1 rst = 1'b0;
        t_reset_and_enable();
        t_line_bits();
        t_rx_and_timeout();
        t_priority();
        t_tx();
        t_pins_and_flow();
        t_wake();
        results();
    end
endmodule
